/* File: rtl/cebh_map.svh */
// Constant map for the external bus host: codes, encodings and defaults.
`ifndef CEBH_MAP_SVH
`define CEBH_MAP_SVH
`define CEBH_SPACE_CPU 3'h7
`define CEBH_IACK_TYPE 4'hF
`define CEBH_IACK_TYPE_HI 19
`define CEBH_IACK_TYPE_LO 16
`define CEBH_LEVEL_HI 3
`define CEBH_LEVEL_LO 1
`define CEBH_ACK_32 2'h0
`define CEBH_ACK_16 2'h1
`define CEBH_ACK_8 2'h2
`define CEBH_ACK_NONE 2'h3
`define CEBH_SIZE_FOUR 2'h0
`define CEBH_BYTES_FOUR 3'h4
`define CEBH_LEVEL_NONE 3'h0
`define CEBH_LEVEL_IDLE_N 3'h7
`define CEBH_DEF_MEM_BYTES 1024
`define CEBH_DEF_PORT_BYTES 4
`define CEBH_DEF_ACK_WAIT 2
`define CEBH_DEF_VEC_BASE 8'h40
`define CEBH_DEF_AUTO_MASK 8'h00
`endif

/* File: rtl/cebh_pkg.sv */
// Types shared by the external bus host modules.
package cebh_pkg;
    typedef enum logic [1:0] {RSP_IDLE = 2'b00, RSP_WAIT = 2'b01, RSP_ACK = 2'b11, RSP_REL = 2'b10} cebh_rsp_e;
    typedef enum logic [1:0] {ARB_IDLE = 2'b00, ARB_REQ = 2'b01, ARB_OWN = 2'b11, ARB_REL = 2'b10} cebh_arb_e;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [2:0] space;
        logic [1:0] size;
        logic rw;
        logic as_n;
        logic ds_n;
        logic bg_n;
        logic halt_n;
        logic pend_n;
        logic lock_n;
    } cebh_pins_s;
    typedef logic [7:0] cebh_vec_t;
endpackage : cebh_pkg

/* File: rtl/cebh_irq_if.sv */
// Carrier between the bus responder and the interrupt encoder.
`timescale 1ns/1ns
`default_nettype none
interface cebh_irq_if;
    logic [2:0] level;
    logic ack_stb;
    logic [2:0] ack_level;
    logic [7:0] vector;
    logic auto_sel;
    modport enc (output level, output vector, output auto_sel, input ack_stb, input ack_level);
    modport rsp (input level, input vector, input auto_sel, output ack_stb, output ack_level);
endinterface : cebh_irq_if
`default_nettype wire

/* File: rtl/cebh_irq_enc.sv */
// Interrupt priority encoder with per-level vector and autovector selection.
`timescale 1ns/1ns
`default_nettype none
`include "cebh_map.svh"
module cebh_irq_enc #(
    parameter logic [7:0] VEC_BASE = `CEBH_DEF_VEC_BASE,
    parameter logic [7:0] AUTO_MASK = `CEBH_DEF_AUTO_MASK
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:1] irq_req,
    output logic irq_served,
    output logic [2:0] irq_served_level,
    cebh_irq_if.enc ifc
);
    import cebh_pkg::*;
    logic [2:0] next_level;

    // ============================================================
    // Priority encoding, highest requesting level wins.
    always_comb
    begin
        next_level = `CEBH_LEVEL_NONE;
        for (int i = 1; i < 8; i++)
        begin
            if (irq_req[i])
            begin
                next_level = 3'(i);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ifc.level <= `CEBH_LEVEL_NONE;
            irq_served <= 1'b0;
            irq_served_level <= `CEBH_LEVEL_NONE;
        end
        else
        begin
            ifc.level <= next_level;
            irq_served <= ifc.ack_stb;
            if (ifc.ack_stb)
            begin
                irq_served_level <= ifc.ack_level;
            end
        end
    end

    assign ifc.vector = VEC_BASE + {5'h00, ifc.ack_level};
    assign ifc.auto_sel = AUTO_MASK[ifc.ack_level];

    // ============================================================
    // Checks.
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_top_level;
        irq_req[7] |=> ifc.level == 3'h7;
    endproperty
    a_top_level: assert property (p_top_level) else $error("Level seven not encoded.");

    property p_any_level;
        (irq_req != 7'h00) |=> ifc.level != `CEBH_LEVEL_NONE;
    endproperty
    a_any_level: assert property (p_any_level) else $error("Pending request not encoded.");
endmodule : cebh_irq_enc
`default_nettype wire

/* File: rtl/cebh_host.sv */
// External bus host: responder, interrupt encoder, alternate master and halt control.
`timescale 1ns/1ns
`default_nettype none
`include "cebh_map.svh"
module cebh_host #(
    parameter int MEM_BYTES = `CEBH_DEF_MEM_BYTES,
    parameter int PORT_BYTES = `CEBH_DEF_PORT_BYTES,
    parameter int ACK_WAIT = `CEBH_DEF_ACK_WAIT,
    parameter logic [7:0] VEC_BASE = `CEBH_DEF_VEC_BASE,
    parameter logic [7:0] AUTO_MASK = `CEBH_DEF_AUTO_MASK
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [31:0] addr,
    input wire logic [2:0] space_code,
    input wire logic xfer_size_hi,
    input wire logic xfer_size_lo,
    input wire logic rw,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic locked_cycle_n,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic [3:0] data_oe,
    output logic xfer_ack_hi_n,
    output logic xfer_ack_lo_n,
    output logic bus_fault_n,
    output logic auto_vector_req_n,
    output logic [2:0] irq_level_n,
    input wire logic irq_pending_n,
    output logic bus_request_n,
    input wire logic bus_grant_n,
    output logic grant_ack_n,
    input wire logic halt_n_in,
    output logic halt_n_out,
    output logic halt_oe,
    output logic cache_off_n,
    input wire logic [7:1] irq_req,
    output logic irq_served,
    output logic [2:0] irq_served_level,
    input wire logic dma_req,
    output logic dma_owned,
    input wire logic halt_req,
    input wire logic cache_disable,
    output logic cpu_halted,
    output logic cpu_irq_pending,
    output logic cpu_locked
);
    import cebh_pkg::*;
    localparam int AW = $clog2(MEM_BYTES);
    localparam logic [1:0] OFF_MASK = 2'(PORT_BYTES - 1);
    localparam logic [1:0] PORT_CODE = (PORT_BYTES == 4) ? `CEBH_ACK_32 :
                                       (PORT_BYTES == 2) ? `CEBH_ACK_16 : `CEBH_ACK_8;

    cebh_irq_if ifc ();
    cebh_pins_s pin_s1;
    cebh_pins_s pin_s2;
    cebh_rsp_e rsp;
    cebh_arb_e arb;
    logic [7:0] mem [MEM_BYTES];
    logic [31:0] addr_q;
    logic [2:0] space_q;
    logic [2:0] bytes_q;
    logic rw_q;
    logic [7:0] wcnt;
    logic [1:0] ack_n;
    logic iack;
    logic miss;
    logic [3:0] lanes;
    logic [AW-1:0] base;
    logic [1:0] own_hist;

    // ============================================================
    // Pin synchronisers, all on the one processor clock.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1 <= '{as_n: 1'b1, ds_n: 1'b1, bg_n: 1'b1, halt_n: 1'b1, pend_n: 1'b1, lock_n: 1'b1, default: '0};
            pin_s2 <= '{as_n: 1'b1, ds_n: 1'b1, bg_n: 1'b1, halt_n: 1'b1, pend_n: 1'b1, lock_n: 1'b1, default: '0};
        end
        else
        begin
            pin_s1 <= '{addr: addr, data: data_in, space: space_code, size: {xfer_size_hi, xfer_size_lo}, rw: rw,
                        as_n: addr_strobe_n, ds_n: data_strobe_n, bg_n: bus_grant_n, halt_n: halt_n_in,
                        pend_n: irq_pending_n, lock_n: locked_cycle_n};
            pin_s2 <= pin_s1;
        end
    end

    // ============================================================
    // Cycle decode and byte lane selection.
    assign iack = (space_q == `CEBH_SPACE_CPU) &&
                  (addr_q[`CEBH_IACK_TYPE_HI:`CEBH_IACK_TYPE_LO] == `CEBH_IACK_TYPE);
    assign miss = !iack && (addr_q[31:AW] != '0);
    assign base = addr_q[AW-1:0] & ~{{(AW-2){1'b0}}, OFF_MASK};

    always_comb
    begin
        lanes = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if ((i < PORT_BYTES) && (i >= int'(addr_q[1:0] & OFF_MASK)) &&
                (i < int'(addr_q[1:0] & OFF_MASK) + int'(bytes_q)))
            begin
                lanes[i] = 1'b1;
            end
        end
    end

    // ============================================================
    // Responder state machine and handshake outputs.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsp <= RSP_IDLE;
            wcnt <= 8'h00;
            addr_q <= 32'h0;
            space_q <= 3'h0;
            bytes_q <= 3'h0;
            rw_q <= 1'b1;
            ack_n <= `CEBH_ACK_NONE;
            bus_fault_n <= 1'b1;
            auto_vector_req_n <= 1'b1;
        end
        else
        begin
            case (rsp)
                RSP_IDLE:
                begin
                    if (!pin_s2.as_n && !pin_s2.ds_n)
                    begin
                        addr_q <= pin_s2.addr;
                        space_q <= pin_s2.space;
                        bytes_q <= (pin_s2.size == `CEBH_SIZE_FOUR) ? `CEBH_BYTES_FOUR : {1'b0, pin_s2.size};
                        rw_q <= pin_s2.rw;
                        wcnt <= 8'(ACK_WAIT);
                        rsp <= RSP_WAIT;
                    end
                end
                RSP_WAIT:
                begin
                    if (wcnt != 8'h00)
                    begin
                        wcnt <= wcnt - 8'h01;
                    end
                    else
                    begin
                        if (miss)
                        begin
                            bus_fault_n <= 1'b0;
                        end
                        else if (iack && ifc.auto_sel)
                        begin
                            auto_vector_req_n <= 1'b0;
                        end
                        else
                        begin
                            ack_n <= PORT_CODE;
                        end
                        rsp <= RSP_ACK;
                    end
                end
                RSP_ACK:
                begin
                    if (pin_s2.as_n)
                    begin
                        ack_n <= `CEBH_ACK_NONE;
                        bus_fault_n <= 1'b1;
                        auto_vector_req_n <= 1'b1;
                        rsp <= RSP_REL;
                    end
                end
                RSP_REL:
                begin
                    rsp <= RSP_IDLE;
                end
                default:
                begin
                    rsp <= RSP_IDLE;
                end
            endcase
        end
    end

    assign {xfer_ack_hi_n, xfer_ack_lo_n} = ack_n;
    assign ifc.ack_stb = (rsp == RSP_WAIT) && (wcnt == 8'h00) && iack;
    assign ifc.ack_level = addr_q[`CEBH_LEVEL_HI:`CEBH_LEVEL_LO];

    // ============================================================
    // Memory, read data drive and write capture.
    always_ff @(posedge clk_sys)
    begin
        if ((rsp == RSP_WAIT) && (wcnt == 8'h00) && !miss && !iack && !rw_q)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (lanes[i])
                begin
                    mem[base + AW'(i)] <= pin_s2.data[31 - 8 * i -: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_out <= 32'h0;
            data_oe <= 4'h0;
        end
        else if ((rsp == RSP_WAIT) && (wcnt == 8'h00) && !miss && rw_q)
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_out[31 - 8 * i -: 8] <= iack ? ifc.vector : mem[base + AW'(i)];
            end
            data_oe <= iack ? (ifc.auto_sel ? 4'h0 : 4'hF) : lanes;
        end
        else if ((rsp == RSP_ACK) && pin_s2.as_n)
        begin
            data_oe <= 4'h0;
        end
    end

    // ============================================================
    // Alternate master arbitration.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            arb <= ARB_IDLE;
            bus_request_n <= 1'b1;
            grant_ack_n <= 1'b1;
        end
        else
        begin
            case (arb)
                ARB_IDLE:
                begin
                    if (dma_req)
                    begin
                        bus_request_n <= 1'b0;
                        arb <= ARB_REQ;
                    end
                end
                ARB_REQ:
                begin
                    if (!pin_s2.bg_n && pin_s2.as_n)
                    begin
                        bus_request_n <= 1'b1;
                        grant_ack_n <= 1'b0;
                        arb <= ARB_OWN;
                    end
                end
                ARB_OWN:
                begin
                    if (!dma_req)
                    begin
                        grant_ack_n <= 1'b1;
                        arb <= ARB_REL;
                    end
                end
                ARB_REL:
                begin
                    arb <= ARB_IDLE;
                end
                default:
                begin
                    arb <= ARB_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Halt, cache control and status.
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            halt_oe <= 1'b0;
            own_hist <= 2'h0;
            cache_off_n <= 1'b1;
            cpu_halted <= 1'b0;
            cpu_irq_pending <= 1'b0;
            cpu_locked <= 1'b0;
        end
        else
        begin
            halt_oe <= halt_req;
            cache_off_n <= !cache_disable;
            // Our own pull lingers two edges in the synchronisers after release.
            own_hist <= {own_hist[0], halt_oe};
            cpu_halted <= !pin_s2.halt_n && !halt_oe && (own_hist == 2'h0);
            cpu_irq_pending <= !pin_s2.pend_n;
            cpu_locked <= !pin_s2.lock_n;
        end
    end

    assign halt_n_out = 1'b0;
    assign dma_owned = (arb == ARB_OWN);
    assign irq_level_n = ~ifc.level;

    cebh_irq_enc #(
        .VEC_BASE(VEC_BASE),
        .AUTO_MASK(AUTO_MASK)
    ) u_irq (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .irq_req(irq_req),
        .irq_served(irq_served),
        .irq_served_level(irq_served_level),
        .ifc(ifc.enc)
    );

    // ============================================================
    // Checks.
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_ack_code;
        (rsp == RSP_WAIT) && (wcnt == 8'h00) && !miss && !(iack && ifc.auto_sel) |=> ack_n == PORT_CODE;
    endproperty
    a_ack_code: assert property (p_ack_code) else $error("Acknowledge code wrong.");

    property p_ack_release;
        (rsp == RSP_ACK) && pin_s2.as_n |=> (ack_n == `CEBH_ACK_NONE) && bus_fault_n && auto_vector_req_n &&
            (data_oe == 4'h0);
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("Answer not released.");

    property p_read_only_drive;
        (data_oe != 4'h0) |-> rw_q && (rsp == RSP_ACK);
    endproperty
    a_read_only_drive: assert property (p_read_only_drive) else $error("Data driven outside a read.");

    property p_fault;
        (rsp == RSP_WAIT) && (wcnt == 8'h00) && miss |=> !bus_fault_n && (ack_n == `CEBH_ACK_NONE);
    endproperty
    a_fault: assert property (p_fault) else $error("Unmapped access not faulted.");

    property p_autovec;
        (rsp == RSP_WAIT) && (wcnt == 8'h00) && iack && ifc.auto_sel |=>
            !auto_vector_req_n && (ack_n == `CEBH_ACK_NONE);
    endproperty
    a_autovec: assert property (p_autovec) else $error("Autovector not requested.");

    property p_request;
        (arb == ARB_IDLE) && dma_req |=> !bus_request_n ##1 (!bus_request_n || !grant_ack_n);
    endproperty
    a_request: assert property (p_request) else $error("Bus request not raised.");

    property p_grant_ack;
        (arb == ARB_REQ) && !pin_s2.bg_n && pin_s2.as_n |=> !grant_ack_n && bus_request_n;
    endproperty
    a_grant_ack: assert property (p_grant_ack) else $error("Grant not acknowledged.");

    property p_halt;
        halt_req |=> halt_oe && !halt_n_out;
    endproperty
    a_halt: assert property (p_halt) else $error("Halt not driven.");
endmodule : cebh_host
`default_nettype wire

/* File: test/cebh_cpu_model.sv */
// Processor-side partner model that drives the external bus pins of the host.
`timescale 1ns/1ns
`default_nettype none
module cebh_cpu_model (
    input wire logic clk_sys,
    output logic [31:0] addr,
    output logic [2:0] space_code,
    output logic xfer_size_hi,
    output logic xfer_size_lo,
    output logic rw,
    output logic addr_strobe_n,
    output logic data_strobe_n,
    output logic locked_cycle_n,
    output logic [31:0] data_in,
    input wire logic [31:0] data_out,
    input wire logic [3:0] data_oe,
    input wire logic xfer_ack_hi_n,
    input wire logic xfer_ack_lo_n,
    input wire logic bus_fault_n,
    input wire logic auto_vector_req_n,
    input wire logic [2:0] irq_level_n,
    output logic irq_pending_n,
    input wire logic bus_request_n,
    output logic bus_grant_n,
    output logic halt_n_in,
    input wire logic halt_n_out,
    input wire logic halt_oe,
    input wire logic cache_off_n,
    input wire logic dbl_fault,
    output logic tmo
);
    // ==========================================================
    // Pin levels and wire resolution
    logic cpu_drv;
    logic cache_on;
    logic [31:0] cpu_dat;
    logic [31:0] last;
    logic ext_cycle_begin_n;
    logic operand_cycle_begin_n;
    logic buffer_en_n;
    initial
    begin
        {ext_cycle_begin_n, operand_cycle_begin_n, buffer_en_n} = 3'h7;
        {addr, cpu_dat, last} = 96'h0;
        {space_code, xfer_size_hi, xfer_size_lo, cpu_drv, tmo} = 7'h00;
        {rw, addr_strobe_n, data_strobe_n, locked_cycle_n, irq_pending_n, bus_grant_n} = 6'h3F;
    end
    // Undriven lanes show the inverse of their last level.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            data_in[31-8*i -: 8] = cpu_drv ? cpu_dat[31-8*i -: 8]
                : (data_oe[i] ? data_out[31-8*i -: 8] : ~last[31-8*i -: 8]);
        end
    end
    always @(posedge clk_sys) last <= data_in;
    assign halt_n_in = ~((halt_oe & ~halt_n_out) | dbl_fault);
    assign cache_on = cache_off_n;
    always @(negedge clk_sys)
    begin
        irq_pending_n <= (irq_level_n == 3'h7);
        bus_grant_n <= bus_request_n | ~addr_strobe_n;
    end
    // ==========================================================
    // One bus cycle
    task automatic cycle(input logic r, input logic [31:0] a, input logic [2:0] sp, input logic [1:0] sz,
        input logic [31:0] wd, input logic lk, output logic [31:0] rd, output logic [3:0] rsp);
        int n;
        @(negedge clk_sys);
        addr = a;
        space_code = sp;
        {xfer_size_hi, xfer_size_lo} = sz;
        rw = r;
        locked_cycle_n = ~lk;
        cpu_dat = wd;
        cpu_drv = ~r;
        buffer_en_n = 1'b0;
        ext_cycle_begin_n = 1'b0;
        operand_cycle_begin_n = 1'b0;
        addr_strobe_n = 1'b0;
        data_strobe_n = 1'b0;
        @(negedge clk_sys);
        {ext_cycle_begin_n, operand_cycle_begin_n} = 2'h3;
        n = 0;
        while (n < 20 && xfer_ack_hi_n && xfer_ack_lo_n && bus_fault_n && auto_vector_req_n)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20)
            tmo = 1'b1;
        rd = data_in;
        rsp = {xfer_ack_hi_n, xfer_ack_lo_n, bus_fault_n, auto_vector_req_n};
        {addr_strobe_n, data_strobe_n, locked_cycle_n, cpu_drv} = 4'hE;
        buffer_en_n = 1'b1;
        n = 0;
        while (n < 20 && !(xfer_ack_hi_n && xfer_ack_lo_n && bus_fault_n && auto_vector_req_n && data_oe == 4'h0))
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20)
            tmo = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask : cycle
endmodule : cebh_cpu_model
`default_nettype wire

/* File: test/tb_cebh_host.sv */
// Self-checking bench for the external bus host.
`timescale 1ns/1ns
`default_nettype none
module tb_cebh_host;
    // ==========================================================
    // Signals, instances and helpers
    logic clk_sys, arst_n, rw, addr_strobe_n, data_strobe_n, locked_cycle_n, xfer_size_hi, xfer_size_lo;
    logic [31:0] addr, data_in, data_out, rd;
    logic [2:0] space_code, irq_level_n, irq_served_level, served_lvl;
    logic [3:0] data_oe, rsp;
    logic xfer_ack_hi_n, xfer_ack_lo_n, bus_fault_n, auto_vector_req_n, irq_pending_n, bus_request_n, bus_grant_n;
    logic grant_ack_n, halt_n_in, halt_n_out, halt_oe, cache_off_n, irq_served, dma_req, dma_owned, halt_req;
    logic cache_disable, cpu_halted, cpu_irq_pending, cpu_locked, dbl_fault, tmo, lock_seen;
    logic [7:1] irq_req;
    logic [5:0] mon;
    int bad_count, checks, served_cnt;
    cebh_host #(.AUTO_MASK(8'h08)) uut (.*);
    cebh_cpu_model cpu (.*);
    assign mon = {bus_request_n, halt_oe, cache_off_n, cpu_irq_pending, cpu_halted, dma_owned};
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (cpu_locked === 1'b1)
            lock_seen = 1'b1;
        if (irq_served === 1'b1)
        begin
            served_cnt++;
            served_lvl = irq_served_level;
        end
    end
    task automatic close_out;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
            bad_count++;
        end
    endtask : chk
    task automatic wt(input int idx, input logic v);
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clk_sys);
            if (mon[idx] === v)
                return;
        end
        $display("Error at %0t: wait on status %0d ran out", $time, idx);
        bad_count++;
        close_out;
    endtask : wt
    task automatic bus(input logic r, input logic [31:0] a, input logic [2:0] sp, input logic [1:0] sz,
        input logic [31:0] wd, input logic lk);
        cpu.cycle(r, a, sp, sz, wd, lk, rd, rsp);
        if (tmo === 1'b1)
        begin
            $display("Error at %0t: bus cycle ran out", $time);
            bad_count++;
            close_out;
        end
    endtask : bus
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk({xfer_ack_hi_n, xfer_ack_lo_n, bus_fault_n, auto_vector_req_n, bus_request_n, grant_ack_n}, 6'h3F, "idle");
        chk({data_oe, halt_oe, cache_off_n, irq_level_n}, 9'h00F, "reset pins");
        chk({irq_served, dma_owned, cpu_halted, cpu_irq_pending, cpu_locked}, 5'h00, "reset status");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_rw;
        bus(1'b0, 32'h00000010, 3'h1, 2'h0, 32'hA1B2C3D4, 1'b1);
        chk(rsp, 4'h3, "long write answer");
        chk(lock_seen, 1'b1, "locked flag");
        bus(1'b0, 32'h00000011, 3'h5, 2'h1, 32'h005E0000, 1'b0);
        chk(rsp, 4'h3, "byte write answer");
        bus(1'b0, 32'h00000012, 3'h5, 2'h2, 32'h00001234, 1'b0);
        bus(1'b1, 32'h00000010, 3'h2, 2'h0, 32'h0, 1'b0);
        chk(rd, 32'hA15E1234, "merged lanes");
        bus(1'b1, 32'h00000013, 3'h6, 2'h1, 32'h0, 1'b0);
        chk(rd[7:0], 8'h34, "byte lane three");
        $display("t_rw done");
    endtask : t_rw
    task automatic t_fault;
        bus(1'b1, 32'h00000400, 3'h1, 2'h0, 32'h0, 1'b0);
        chk(rsp, 4'hD, "unmapped answer");
        $display("t_fault done");
    endtask : t_fault
    task automatic t_irq;
        irq_req = 7'h02;
        repeat (2) @(negedge clk_sys);
        chk(irq_level_n, 3'h5, "level two code");
        wt(2, 1'b1);
        irq_req = 7'h14;
        repeat (2) @(negedge clk_sys);
        chk(irq_level_n, 3'h2, "level five code");
        bus(1'b1, 32'h000F000A, 3'h7, 2'h0, 32'h0, 1'b0);
        chk(rsp, 4'h3, "vector answer");
        chk(rd, 32'h45454545, "vector lanes");
        chk({served_cnt[3:0], served_lvl}, 7'h0D, "served level");
        bus(1'b1, 32'h000F0006, 3'h7, 2'h0, 32'h0, 1'b0);
        chk(rsp, 4'hE, "autovector answer");
        irq_req = 7'h40;
        repeat (2) @(negedge clk_sys);
        chk(irq_level_n, 3'h0, "level seven code");
        irq_req = 7'h00;
        wt(2, 1'b0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_arb;
        dma_req = 1'b1;
        wt(5, 1'b0);
        wt(0, 1'b1);
        chk({bus_request_n, grant_ack_n}, 2'h2, "owner pins");
        dma_req = 1'b0;
        wt(0, 1'b0);
        chk(grant_ack_n, 1'b1, "released");
        $display("t_arb done");
    endtask : t_arb
    task automatic t_halt;
        halt_req = 1'b1;
        wt(4, 1'b1);
        repeat (4) @(negedge clk_sys);
        chk({halt_n_in, cpu_halted}, 2'h0, "own halt");
        halt_req = 1'b0;
        wt(4, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            @(negedge clk_sys);
            chk(cpu_halted, 1'b0, "own halt released");
        end
        dbl_fault = 1'b1;
        wt(1, 1'b1);
        dbl_fault = 1'b0;
        wt(1, 1'b0);
        $display("t_halt done");
    endtask : t_halt
    task automatic t_cache;
        cache_disable = 1'b1;
        wt(3, 1'b0);
        cache_disable = 1'b0;
        wt(3, 1'b1);
        $display("t_cache done");
    endtask : t_cache
    initial
    begin
        {arst_n, dma_req, halt_req, cache_disable, dbl_fault, lock_seen} = 6'h00;
        irq_req = 7'h00;
        repeat (8) @(negedge clk_sys);
        t_reset;
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_rw;
        t_fault;
        t_irq;
        t_arb;
        t_halt;
        t_cache;
        close_out;
    end
endmodule : tb_cebh_host
`default_nettype wire
